// File: hdl/lbf_pkg.sv
package lbf_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 5;
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int NVM_MS = 8;
   localparam int NVM_CYC = CLK_HZ / 1000 * NVM_MS;
   localparam int CNT_W = 20;
   localparam logic [7:0] IFT_DEFAULT = 8'h38;
   // ---------------------------------------------------------------
   // Frame and message sizes
   // ---------------------------------------------------------------
   localparam int MAX_FIELD = 128;
   localparam int FRAME_MAX = MAX_FIELD + 1;
   localparam int HDR_LEN = 7;
   localparam int MSG_MAX = 137;
   localparam logic [7:0] EOT_MAX = 8'(MSG_MAX - HDR_LEN);
   localparam logic [7:0] PASS_LEN = 8'h07;
   localparam logic [47:0] PASS1 = 48'h4c494e504153;
   localparam logic [47:0] PASS2 = 48'h504852415345;
   // ---------------------------------------------------------------
   // Message types, commands and answer codes
   // ---------------------------------------------------------------
   localparam logic [7:0] T_EOT = 8'h80;
   localparam logic [7:0] T_ACK = 8'h81;
   localparam logic [7:0] ACK_LEN = 8'h02;
   localparam logic [7:0] C_RAMW = 8'h02;
   localparam logic [7:0] C_RAMX = 8'h83;
   localparam logic [7:0] C_RAMR = 8'h84;
   localparam logic [7:0] C_NVMW = 8'h05;
   localparam logic [7:0] C_NVMX = 8'h86;
   localparam logic [7:0] C_NVMR = 8'h87;
   localparam logic [7:0] C_BAUD = 8'h93;
   localparam int N_CMD = 21;
   localparam logic [167:0] CMD_LIST = {8'h02, 8'h83, 8'h84, 8'h05, 8'h86, 8'h87, 8'h88,
      8'h89, 8'h8a, 8'h8b, 8'h0c, 8'h0d, 8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92, 8'h93, 8'h97,
      8'h98, 8'h99};
   localparam logic [47:0] DATA_LIST = {8'h84, 8'h87, 8'h8e, 8'h90, 8'h92, 8'h0c};
   localparam logic [31:0] NVMW_LIST = {8'h05, 8'h88, 8'h0d, 8'h97};
   localparam logic [7:0] E_OK = 8'h00;
   localparam logic [7:0] E_VALID = 8'h01;
   localparam logic [7:0] E_RANGE = 8'h02;
   localparam logic [7:0] E_PARAM = 8'h03;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {B38K4, B115K2, B230K4} lbf_baud_type;
   typedef enum logic [2:0] {S_RX, S_CHECK, S_STREAM, S_EXEC, S_RESP} lbf_st_type;
   typedef struct packed {
      logic [7:0] mtype;
      logic [23:0] addr;
      logic [7:0] num;
      logic [7:0] elen;
   } lbf_cmd_type;
   typedef struct packed {
      lbf_st_type st;
      logic rxr;
      logic [7:0] idx;
      logic [7:0] sum;
      logic [7:0] flen;
      logic unl;
      logic stg1;
      logic [7:0] nad;
      logic nacx;
      logic [CNT_W-1:0] pre;
      logic [7:0] tck;
      logic weot;
      lbf_cmd_type hdr;
      logic cmdv;
      logic [7:0] sidx;
      logic [1:0] fcnt;
      logic dv;
      logic [7:0] f0;
      logic [7:0] f1;
      logic [7:0] code;
      logic [1:0] txi;
      logic txv;
      logic [7:0] txd;
      lbf_baud_type baud;
      lbf_baud_type bnew;
      logic bpend;
      logic [CNT_W-1:0] busy;
      logic bz;
   } lbf_state_type;

   function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction : add8
endpackage : lbf_pkg

// File: hdl/lbf_frame_cmd.sv
`timescale 1ns/10ps
// Function
// - Page rewrite takes 8 ms before answering.
// - Before sync, timeouts use no-activity timeout.
// - After sync, time only frames in progress.
// - Unlock needs both passphrase frames before expiry.
// - Link runs at 38.4, 115.2, 230.4 kBd.
// - Start at 115.2 kBd; command 93 changes.
// - Drop every frame with bad checksum.
// - Join accepted frames into whole commands.
// - Response frame: block plus its checksum.
// - Checksum: inverted end-around-carry byte sum.
// - Data commands send data or error, no ack.
// - Execute commands answer only on failure.
// - Inconsistent frames dropped without any reply.
// - Unknown command answered with validity failure.
// - Decoder accepts exactly the listed command codes.
// - Filler bytes ignored whatever their value.
// - Padding to 128 bytes; checksum last.
// - RAM write into loader area is refused.
// - Memory commands check range and nonzero count.
// - Interframe timeout in 5 ms units, 0x38.
// - Type MSB set: single block; else EOT.
module lbf_frame_cmd #(
   parameter int TICK_CYC = lbf_pkg::TICK_CYC,
   parameter int NVM_CYC = lbf_pkg::NVM_CYC,
   parameter int RAM_SIZE = 32'h0000_2000,
   parameter int RAM_PROT = 32'h0000_1c00,
   parameter int NVM_SIZE = 32'h0001_0000
) (
   input wire logic CORE_CLK_IN,
   input wire logic NRST_IN,
   input wire logic RX_VALID_IN,
   input wire logic [7:0] RX_DATA_IN,
   input wire logic RX_LAST_IN,
   input wire logic DATA_READY_IN,
   input wire logic TX_READY_IN,
   input wire logic EXEC_DONE_IN,
   input wire logic [7:0] EXEC_CODE_IN,
   input wire logic [7:0] NAC_TIME_IN,
   input wire logic [7:0] IFT_TIME_IN,
   output logic RX_READY_OUT,
   output logic CMD_VALID_OUT,
   output lbf_pkg::lbf_cmd_type CMD_OUT,
   output logic DATA_VALID_OUT,
   output logic [7:0] DATA_OUT,
   output logic TX_VALID_OUT,
   output logic [7:0] TX_DATA_OUT,
   output lbf_pkg::lbf_baud_type BAUD_SEL_OUT,
   output logic UNLOCKED_OUT,
   output logic NAC_EXPIRED_OUT,
   output logic NVM_BUSY_OUT
);
   lbf_pkg::lbf_state_type st_r;
   lbf_pkg::lbf_state_type st_nxt;
   logic [7:0] mem [0:lbf_pkg::FRAME_MAX];
   logic acc;

   function automatic logic in_list(input logic [7:0] t, input logic [167:0] l, input int n);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < n; i++) begin
         hit = hit | (l[i*8 +: 8] == t);
      end
      return hit;
   endfunction : in_list

   assign acc = st_r.rxr && RX_VALID_IN;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      lbf_pkg::lbf_cmd_type h;
      logic [47:0] pw;
      logic run;
      logic tout;
      logic go;
      logic pop;
      logic push;
      logic [7:0] lim8;
      logic [24:0] lim;
      logic [24:0] top;
      logic [7:0] d;
      h = st_r.hdr;
      run = 1'b0;
      tout = 1'b0;
      pop = 1'b0;
      lim8 = 8'h00;
      pw = 48'h0;
      go = 1'b0;
      push = 1'b0;
      d = 8'h00;
      lim = 25'h0;
      top = 25'h0;
      st_nxt = st_r;
      st_nxt.cmdv = 1'b0;
      // Receiver: frames are buffered whole and judged at the checksum byte.
      if (acc) begin
         if (RX_LAST_IN) begin
            st_nxt.idx = 8'h00;
            st_nxt.sum = 8'h00;
            if (~st_r.sum == RX_DATA_IN && st_r.idx != 8'h00 &&
                st_r.idx <= 8'(lbf_pkg::FRAME_MAX) &&
                (!st_r.unl || mem[0] < st_r.idx)) begin
               st_nxt.flen = st_r.idx;
               st_nxt.st = lbf_pkg::S_CHECK;
            end
         end else begin
            if (st_r.idx != 8'(lbf_pkg::FRAME_MAX + 1)) begin
               st_nxt.idx = st_r.idx + 8'h01;
            end
            if (!st_r.unl || st_r.idx == 8'h00 || st_r.idx <= mem[0]) begin
               st_nxt.sum = lbf_pkg::add8(st_r.sum, RX_DATA_IN);
            end
         end
      end
      // Frame timer: no-activity before unlock, interframe after it.
      run = st_r.unl ? (st_r.st == lbf_pkg::S_RX && st_r.idx != 8'h00) : !st_r.nacx;
      lim8 = st_r.unl ? IFT_TIME_IN : NAC_TIME_IN;
      tout = run && st_r.tck >= lim8;
      if (!run) begin
         st_nxt.pre = '0;
         st_nxt.tck = 8'h00;
      end else if (st_r.pre == lbf_pkg::CNT_W'(TICK_CYC - 1)) begin
         st_nxt.pre = '0;
         st_nxt.tck = st_r.tck + {7'h00, st_r.tck != 8'hff};
      end else begin
         st_nxt.pre = st_r.pre + 1'b1;
      end
      if (tout) begin
         st_nxt.nacx = st_r.nacx | !st_r.unl;
         st_nxt.idx = 8'h00;
         st_nxt.sum = 8'h00;
      end
      // Output buffer: head entry always in f0 so the data port is a flop.
      pop = st_r.fcnt != 2'd0 && DATA_READY_IN;
      if (pop) begin
         st_nxt.f0 = st_r.f1;
         st_nxt.fcnt = st_r.fcnt - 2'd1;
      end
      if (st_r.busy != '0) begin
         st_nxt.busy = st_r.busy - 1'b1;
      end
      unique case (st_r.st)
         lbf_pkg::S_RX: begin
         end
         lbf_pkg::S_CHECK: begin
            st_nxt.st = lbf_pkg::S_RX;
            if (!st_r.unl) begin
               for (int i = 1; i < 7; i++) begin
                  pw = {pw[39:0], mem[i]};
               end
               st_nxt.stg1 = 1'b0;
               if (!st_r.nacx && st_r.flen == lbf_pkg::PASS_LEN) begin
                  if (pw == lbf_pkg::PASS1) begin
                     st_nxt.stg1 = 1'b1;
                     st_nxt.nad = mem[0];
                  end else if (pw == lbf_pkg::PASS2 && st_r.stg1 && mem[0] == st_r.nad) begin
                     st_nxt.unl = 1'b1;
                  end
               end
            end else if (!st_r.weot) begin
               // Unused header bytes are never looked at.
               h = '{mem[1], {mem[2], mem[3], mem[4]}, mem[6], 8'h00};
               if (mem[1] != lbf_pkg::T_EOT) begin
                  st_nxt.hdr = h;
                  go = mem[1][7];
                  st_nxt.weot = !mem[1][7];
               end
            end else begin
               st_nxt.weot = 1'b0;
               h.elen = mem[0] - 8'h01;
               st_nxt.hdr.elen = h.elen;
               go = mem[1] == lbf_pkg::T_EOT && h.elen <= lbf_pkg::EOT_MAX;
            end
         end
         lbf_pkg::S_STREAM: begin
            push = st_r.sidx != st_r.hdr.elen && (st_r.fcnt != 2'd2 || pop);
            d = mem[8'(st_r.sidx + 8'h02)];
            if (push) begin
               st_nxt.sidx = st_r.sidx + 8'h01;
            end else if (st_r.sidx == st_r.hdr.elen) begin
               st_nxt.st = lbf_pkg::S_EXEC;
            end
         end
         lbf_pkg::S_EXEC: begin
            if (EXEC_DONE_IN) begin
               st_nxt.code = EXEC_CODE_IN;
               st_nxt.txi = 2'd0;
               st_nxt.st = lbf_pkg::S_RESP;
               if (EXEC_CODE_IN == lbf_pkg::E_OK) begin
                  if (in_list(st_r.hdr.mtype, {120'h0, lbf_pkg::DATA_LIST}, 6) ||
                      st_r.hdr.mtype == lbf_pkg::C_RAMX ||
                      st_r.hdr.mtype == lbf_pkg::C_NVMX) begin
                     st_nxt.st = lbf_pkg::S_RX;
                  end
                  if (st_r.hdr.mtype == lbf_pkg::C_BAUD) begin
                     if (st_r.hdr.addr[23:16] > 8'h02) begin
                        st_nxt.code = lbf_pkg::E_PARAM;
                     end else begin
                        st_nxt.bpend = 1'b1;
                        st_nxt.bnew = lbf_pkg::lbf_baud_type'(st_r.hdr.addr[17:16]);
                     end
                  end
               end
            end
         end
         lbf_pkg::S_RESP: begin
            // Answers are held back while a page rewrite is still running.
            if (st_r.busy == '0 && !st_r.txv) begin
               st_nxt.txv = 1'b1;
               unique case (st_r.txi)
                  2'd0: st_nxt.txd = lbf_pkg::ACK_LEN;
                  2'd1: st_nxt.txd = lbf_pkg::T_ACK;
                  2'd2: st_nxt.txd = st_r.code;
                  2'd3: st_nxt.txd = ~lbf_pkg::add8(lbf_pkg::add8(lbf_pkg::ACK_LEN,
                                         lbf_pkg::T_ACK), st_r.code);
               endcase
            end else if (st_r.txv && TX_READY_IN) begin
               st_nxt.txv = 1'b0;
               st_nxt.txi = st_r.txi + 2'd1;
               if (st_r.txi == 2'd3) begin
                  st_nxt.st = lbf_pkg::S_RX;
                  st_nxt.bpend = 1'b0;
                  if (st_r.bpend) begin
                     st_nxt.baud = st_r.bnew;
                  end
               end
            end
         end
         default: st_nxt.st = lbf_pkg::S_RX;
      endcase
      // Command checks at dispatch.
      if (go) begin
         unique case (h.mtype)
            lbf_pkg::C_RAMW: lim = 25'(RAM_PROT);
            lbf_pkg::C_RAMR: lim = 25'(RAM_SIZE);
            lbf_pkg::C_NVMW, lbf_pkg::C_NVMR: lim = 25'(NVM_SIZE);
            default: lim = 25'h0;
         endcase
         top = {1'b0, h.addr} + {17'h0, h.num};
         st_nxt.txi = 2'd0;
         st_nxt.st = lbf_pkg::S_RESP;
         if (!in_list(h.mtype, lbf_pkg::CMD_LIST, lbf_pkg::N_CMD)) begin
            st_nxt.code = lbf_pkg::E_VALID;
         end else if (lim != 25'h0 && h.num == 8'h00) begin
            st_nxt.code = lbf_pkg::E_PARAM;
         end else if (lim != 25'h0 && top > lim) begin
            st_nxt.code = lbf_pkg::E_RANGE;
         end else begin
            st_nxt.cmdv = 1'b1;
            st_nxt.sidx = 8'h00;
            st_nxt.st = lbf_pkg::S_STREAM;
            if (in_list(h.mtype, {136'h0, lbf_pkg::NVMW_LIST}, 4)) begin
               st_nxt.busy = lbf_pkg::CNT_W'(NVM_CYC);
            end
         end
      end
      if (push) begin
         if (st_nxt.fcnt == 2'd0) begin
            st_nxt.f0 = d;
         end else begin
            st_nxt.f1 = d;
         end
         st_nxt.fcnt = st_nxt.fcnt + 2'd1;
      end
      st_nxt.dv = st_nxt.fcnt != 2'd0;
      st_nxt.bz = st_nxt.busy != '0;
      st_nxt.rxr = st_nxt.st == lbf_pkg::S_RX;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         st_r <= '0;
         st_r.rxr <= 1'b1;
         st_r.baud <= lbf_pkg::B115K2;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (acc && !RX_LAST_IN && st_r.idx <= 8'(lbf_pkg::FRAME_MAX)) begin
         mem[st_r.idx] <= RX_DATA_IN;
      end
   end

   assign RX_READY_OUT = st_r.rxr;
   assign CMD_VALID_OUT = st_r.cmdv;
   assign CMD_OUT = st_r.hdr;
   assign DATA_VALID_OUT = st_r.dv;
   assign DATA_OUT = st_r.f0;
   assign TX_VALID_OUT = st_r.txv;
   assign TX_DATA_OUT = st_r.txd;
   assign BAUD_SEL_OUT = st_r.baud;
   assign UNLOCKED_OUT = st_r.unl;
   assign NAC_EXPIRED_OUT = st_r.nacx;
   assign NVM_BUSY_OUT = st_r.bz;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!NRST_IN);

   property p_bad_sum;
      acc && RX_LAST_IN && (~st_r.sum != RX_DATA_IN) |=> st_r.st != lbf_pkg::S_CHECK;
   endproperty
   a_bad_sum: assert property (p_bad_sum) else $error("bad checksum frame kept");
   property p_nac_lock;
      !st_r.unl && st_r.nacx |=> !st_r.unl && st_r.nacx;
   endproperty
   a_nac_lock: assert property (p_nac_lock) else $error("unlock after expiry");
   property p_unlock;
      $rose(st_r.unl) |-> $past(st_r.stg1) && !$past(st_r.nacx);
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock without passphrase");
   property p_baud;
      $changed(BAUD_SEL_OUT) |-> $past(st_r.st == lbf_pkg::S_RESP && st_r.bpend);
   endproperty
   a_baud: assert property (p_baud) else $error("baud changed unexpectedly");
   property p_known;
      CMD_VALID_OUT |-> in_list(CMD_OUT.mtype, lbf_pkg::CMD_LIST, lbf_pkg::N_CMD);
   endproperty
   a_known: assert property (p_known) else $error("unknown command dispatched");
   property p_count;
      CMD_VALID_OUT && (CMD_OUT.mtype == lbf_pkg::C_RAMW || CMD_OUT.mtype == lbf_pkg::C_RAMR)
         |-> CMD_OUT.num != 8'h00 && {1'b0, CMD_OUT.addr} + {17'h0, CMD_OUT.num} <= 25'(RAM_SIZE);
   endproperty
   a_count: assert property (p_count) else $error("bad memory count passed");
   property p_noack;
      st_r.st == lbf_pkg::S_EXEC && EXEC_DONE_IN && EXEC_CODE_IN == lbf_pkg::E_OK &&
         st_r.hdr.mtype == lbf_pkg::C_RAMR |=> st_r.st == lbf_pkg::S_RX [*2];
   endproperty
   a_noack: assert property (p_noack) else $error("ack sent with data");
   property p_idle;
      st_r.unl && st_r.st == lbf_pkg::S_RX && st_r.idx == 8'h00 |=> st_r.tck == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("timer ran while idle");
   property p_txsum;
      TX_VALID_OUT && st_r.txi == 2'd3 |-> TX_DATA_OUT == ~lbf_pkg::add8(8'h83, st_r.code);
   endproperty
   a_txsum: assert property (p_txsum) else $error("response checksum wrong");
   c_unlock: cover property ($rose(st_r.unl));
   c_cmd: cover property (CMD_VALID_OUT ##[1:200] DATA_VALID_OUT && DATA_READY_IN);
   c_resp: cover property (TX_VALID_OUT && TX_READY_IN && st_r.txi == 2'd3);
endmodule : lbf_frame_cmd

// File: bench/lbf_host_model.sv
`timescale 1ns/10ps
module lbf_host_model (
   input wire logic clk_in,
   input wire logic rx_ready_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic rx_last_out,
   output logic tx_ready_out
);
   // ---------------------------------------------------------------
   // Programming host on the far side of the serial link
   // ---------------------------------------------------------------
   logic [7:0] resp_q[$];
   int quiet = 0;
   int left = 0;
   logic [1:0] cyc = 2'h0;
   bit sending = 1'b0;
   initial begin
      rx_valid_out = 1'b0;
      rx_data_out = 8'h00;
      rx_last_out = 1'b0;
      tx_ready_out = 1'b0;
   end
   // The host stalls one cycle in four, so each response byte has to stand until taken.
   always @(posedge clk_in) begin
      cyc <= cyc + 2'h1;
      tx_ready_out <= (cyc != 2'h2);
      if (quiet > 0) quiet <= quiet - 1;
      // An idle data line toggles so that a stale byte is never mistaken for a fresh one.
      if (!sending) rx_data_out <= ~rx_data_out;
      if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
         resp_q.push_back(tx_data_in);
         left = (left == 0) ? int'(tx_data_in) + 1 : left - 1;
         if (left == 0) quiet <= 800;
      end
   end
   task automatic send_frame(input logic [7:0] fr[$], input bit cut);
      while (quiet > 0) @(posedge clk_in);
      repeat (4) @(posedge clk_in);
      sending = 1'b1;
      @(posedge clk_in);
      foreach (fr[i]) begin
         rx_valid_out <= 1'b1;
         rx_data_out <= fr[i];
         rx_last_out <= !cut && (i == fr.size() - 1);
         do @(posedge clk_in); while (rx_ready_in !== 1'b1);
      end
      rx_valid_out <= 1'b0;
      rx_last_out <= 1'b0;
      sending = 1'b0;
   endtask : send_frame
endmodule : lbf_host_model

// File: bench/test_lin_boot_loader_frame_cmd.sv
`timescale 1ns/10ps
module test_lin_boot_loader_frame_cmd;
   // ---------------------------------------------------------------
   // Bench with a queue model of commands, data and responses
   // ---------------------------------------------------------------
   localparam int TICK = 20;
   localparam int NVMC = 50;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic dready = 1'b0;
   logic exec_done = 1'b0;
   logic [7:0] exec_code = 8'h00;
   logic [7:0] nac_time = 8'hff;
   logic [7:0] ift_time = 8'h38;
   logic [7:0] seed = 8'h1a;
   logic rx_valid, rx_last, rx_ready, tx_valid, tx_ready;
   logic cmd_valid, data_valid, unlocked, nac_exp, nvm_busy;
   logic [7:0] rx_data, tx_data, data;
   lbf_pkg::lbf_cmd_type cmd;
   lbf_pkg::lbf_baud_type baud;
   int fail_count = 0;
   int check_count = 0;
   int cmd_cnt = 0;
   logic [7:0] data_q[$], hq[$], eq[$], q[$];
   logic [7:0] uc[3] = '{8'hff, 8'h94, 8'h85};
   logic [7:0] sc[7] = '{8'h84, 8'h87, 8'h8e, 8'h90, 8'h92, 8'h83, 8'h86};
   logic [7:0] ac[9] = '{8'h89, 8'h8a, 8'h8b, 8'h8f, 8'h91, 8'h98, 8'h99, 8'h88, 8'h97};
   logic [7:0] mc[4] = '{8'h02, 8'h05, 8'h0d, 8'h0c};
   string mn[4] = '{"multi", "nvm", "nvm", "multi"};
   int mr[4] = '{0, 0, 0, -1};
   logic [7:0] bv[4] = '{8'h02, 8'h00, 8'h01, 8'h03};
   logic [1:0] bb[4] = '{2'h2, 2'h0, 2'h1, 2'h1};
   initial begin
      forever #12.5 clk = ~clk;
   end
   lbf_frame_cmd #(.TICK_CYC(TICK), .NVM_CYC(NVMC)) i_lbf_frame_cmd (.CORE_CLK_IN(clk),
      .NRST_IN(nrst), .RX_VALID_IN(rx_valid), .RX_DATA_IN(rx_data), .RX_LAST_IN(rx_last),
      .DATA_READY_IN(dready), .TX_READY_IN(tx_ready), .EXEC_DONE_IN(exec_done),
      .EXEC_CODE_IN(exec_code), .NAC_TIME_IN(nac_time), .IFT_TIME_IN(ift_time),
      .RX_READY_OUT(rx_ready), .CMD_VALID_OUT(cmd_valid), .CMD_OUT(cmd),
      .DATA_VALID_OUT(data_valid), .DATA_OUT(data), .TX_VALID_OUT(tx_valid),
      .TX_DATA_OUT(tx_data), .BAUD_SEL_OUT(baud), .UNLOCKED_OUT(unlocked),
      .NAC_EXPIRED_OUT(nac_exp), .NVM_BUSY_OUT(nvm_busy));
   lbf_host_model i_lbf_host_model (.clk_in(clk), .rx_ready_in(rx_ready), .tx_valid_in(tx_valid),
      .tx_data_in(tx_data), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
      .rx_last_out(rx_last), .tx_ready_out(tx_ready));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   always @(posedge clk) begin
      seed <= lfsr(seed);
      dready <= seed[0] | seed[1];
      if (cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 1;
      if (data_valid === 1'b1 && dready === 1'b1) data_q.push_back(data);
   end
   function automatic logic [7:0] chk(input logic [7:0] b[$]);
      int s;
      s = 0;
      foreach (b[i]) begin
         s = s + int'(b[i]);
         if (s >= 256) s = s - 255;
      end
      return ~s[7:0];
   endfunction : chk
   function automatic void hdr(input logic [7:0] t, input logic [23:0] a, input logic [7:0] n);
      hq = {8'h06, t, a[23:16], a[15:8], a[7:0], 8'h00, n};
      hq.push_back(chk(hq));
   endfunction : hdr
   function automatic void eot(input int n, input int pad);
      logic [7:0] c;
      eq = {8'(n + 1), 8'h80};
      for (int i = 0; i < n; i++) eq.push_back(seed ^ 8'(i * 37));
      c = chk(eq);
      // Padding carries arbitrary values; only the real data may come out.
      for (int i = 0; i < pad; i++) eq.push_back(seed + 8'(i));
      eq.push_back(c);
   endfunction : eot
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (exp !== got) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic unlock();
      q = {8'h5a, 8'h4c, 8'h49, 8'h4e, 8'h50, 8'h41, 8'h53};
      q.push_back(chk(q));
      i_lbf_host_model.send_frame(q, 1'b0);
      q = {8'h5a, 8'h50, 8'h48, 8'h52, 8'h41, 8'h53, 8'h45};
      q.push_back(chk(q));
      i_lbf_host_model.send_frame(q, 1'b0);
      repeat (4) @(posedge clk);
   endtask : unlock
   task automatic run(input string what, input bit eot_on, input int nd, input logic [7:0] ec,
      input bit pulse, input int rc);
      int c0;
      int n;
      c0 = cmd_cnt;
      data_q.delete();
      i_lbf_host_model.resp_q.delete();
      i_lbf_host_model.send_frame(hq, 1'b0);
      if (eot_on) i_lbf_host_model.send_frame(eq, 1'b0);
      n = 0;
      while (cmd_cnt == c0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check({what, " dispatch"}, pulse, cmd_cnt != c0);
      if (pulse) begin
         check({what, " type"}, hq[1], cmd.mtype);
         check({what, " addr"}, {hq[2], hq[3], hq[4]}, cmd.addr);
         check({what, " num"}, hq[6], cmd.num);
         check({what, " busy"}, what == "nvm", nvm_busy);
         n = 0;
         while (data_q.size() < nd && n < 2000) begin
            @(posedge clk);
            n++;
         end
         foreach (data_q[i]) check({what, " data"}, eq[2 + i], data_q[i]);
         @(posedge clk);
         exec_done <= 1'b1;
         exec_code <= ec;
         @(posedge clk);
         exec_done <= 1'b0;
         repeat (4) @(posedge clk);
         if (what == "nvm") check({what, " early"}, 0, i_lbf_host_model.resp_q.size());
      end
      n = 0;
      while (i_lbf_host_model.resp_q.size() < 4 && n < 600) begin
         @(posedge clk);
         n++;
      end
      if (rc < 0) begin
         check({what, " silent"}, 0, i_lbf_host_model.resp_q.size());
      end else begin
         q = {8'h02, lbf_pkg::T_ACK, 8'(rc)};
         q.push_back(chk(q));
         foreach (q[i]) check({what, " resp"}, q[i], i_lbf_host_model.resp_q[i]);
      end
      check({what, " count"}, nd, data_q.size());
      $display("test %s done", what);
   endtask : run
   initial begin
      repeat (95000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check("ready", 1, rx_ready);
      check("baud", lbf_pkg::B115K2, baud);
      hdr(lbf_pkg::C_RAMR, 24'h000000, 8'h04);
      run("locked", 1'b0, 0, 8'h00, 1'b0, -1);
      unlock();
      check("unlocked", 1, unlocked);
      check("nac", 0, nac_exp);
      repeat (2000) @(posedge clk);
      i_lbf_host_model.send_frame(hq[0:2], 1'b1);
      repeat (1500) @(posedge clk);
      hq[7] = hq[7] ^ 8'h01;
      run("bad sum", 1'b0, 0, 8'h00, 1'b0, -1);
      foreach (uc[i]) begin
         hdr(uc[i], 24'h000000, 8'h04);
         run("unknown", 1'b0, 0, 8'h00, 1'b0, 1);
      end
      foreach (sc[i]) begin
         hdr(sc[i], 24'h000000, 8'h04);
         run("quiet", 1'b0, 0, 8'h00, 1'b1, -1);
      end
      hdr(lbf_pkg::C_RAMR, 24'h000000, 8'h04);
      run("read error", 1'b0, 0, 8'h02, 1'b1, 2);
      foreach (ac[i]) begin
         hdr(ac[i], 24'h000000, 8'h04);
         run((ac[i] == 8'h88 || ac[i] == 8'h97) ? "nvm" : "ack", 1'b0, 0, 8'h00, 1'b1, 0);
      end
      foreach (mc[i]) begin
         hdr(mc[i], 24'h000020, 8'h03);
         eot(3, 2);
         run(mn[i], 1'b1, 3, 8'h00, 1'b1, mr[i]);
      end
      hdr(lbf_pkg::C_RAMW, 24'h001c00, 8'h04);
      eot(4, 0);
      run("protected", 1'b1, 0, 8'h00, 1'b0, 2);
      hdr(lbf_pkg::C_RAMR, 24'h001c00, 8'h04);
      run("read top", 1'b0, 0, 8'h00, 1'b1, -1);
      hdr(lbf_pkg::C_RAMR, 24'h000000, 8'h00);
      run("zero", 1'b0, 0, 8'h00, 1'b0, 3);
      hdr(lbf_pkg::C_RAMR, 24'h001ffe, 8'h04);
      run("over", 1'b0, 0, 8'h00, 1'b0, 2);
      foreach (bv[i]) begin
         hdr(lbf_pkg::C_BAUD, {bv[i], 16'h0000}, 8'h00);
         run("baud", 1'b0, 0, 8'h00, 1'b1, (bv[i] < 8'h03) ? 0 : 3);
         repeat (2) @(posedge clk);
         check("baud sel", bb[i], baud);
      end
      nrst <= 1'b0;
      nac_time <= 8'h04;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (2 * TICK) @(posedge clk);
      check("nac early", 0, nac_exp);
      repeat (4 * TICK) @(posedge clk);
      check("nac expired", 1, nac_exp);
      unlock();
      check("late unlock", 0, unlocked);
      $display("test nac expiry done");
      conclude();
   end
endmodule : test_lin_boot_loader_frame_cmd
